// file: design/opa_program_write_strobe_access.sv
// Purpose: Access-mode logic of the OTP parallel programming interface.
// Assumes: All pins synchronous to ref_clk; programming mode entry is external.
// Notes:   Read data lags the read strobe fall by one clock.
//
// Contract
// - Byte mode arms when select reads 1,1 at the latch strobe rise.
// - Latch strobe fall captures address bits 8..13 from the address port.
// - Latched page persists across accesses until the next latch strobe.
// - Lock pair 11,10,01,00 gives levels 0..3; zero means programmed.
// - Level 0 disables locking; external access pin not latched at reset.
// - Level 2 adds blocking of verify mode 2 reads.
// - Level 3 also ignores external access pin; internal jumps still leave.
// - New protection applies only after programming mode is exited.
// - Lock bits always readable while level 0 is in force.
// - Levels 1..3 committed refuse programming mode re-entry.
// - Version bytes at FC, FD, FE readable in version mode.
// - Version bytes are read only; writes leave them unchanged.
// - Version bytes map as registers in normal mode when map select set.
// - Version bytes are maker code, device type code, stepping code.
// - Later steppings change version byte 2; bytes 0 and 1 stay.
// - Select 1,0 is lock access, 0,1 is version read.
// - Read and write strobes active low, latch strobe active high; data on port 0, address on port 2.
`timescale 1ns/1ps
`default_nettype none
`include "opa_defines.svh"
module opa_program_write_strobe_access
    import opa_pkg::*;
#(
    parameter int          LOCK_PULSE_CYC = `OPA_LOCK_PULSE_US * `OPA_CLK_MHZ,
    parameter logic [7:0]  VER_STEP       = `OPA_VER_STEP
)(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       program_write_strobe_mode_active,
    input  wire logic [1:0] access_mode_select,
    input  wire logic       address_latch_strobe,
    input  wire logic       program_write_strobe_n,
    input  wire logic       program_read_strobe_n,
    input  wire logic [7:0] address_port,
    input  wire logic [7:0] version_address_port,
    input  wire logic [7:0] data_port_in,
    output logic      [7:0] data_port_out,
    output logic            data_port_oe,
    input  wire logic       device_in_reset,
    input  wire logic       external_access_pin,
    input  wire logic       sfr_map_select,
    input  wire logic       sfr_read,
    input  wire logic [7:0] sfr_address,
    output logic      [7:0] sfr_read_data,
    output logic      [1:0] protection_level,
    output logic            program_write_strobe_entry_refused,
    output logic            table_read_blocked,
    output logic            verify_mode2_blocked,
    output logic            programming_blocked,
    output logic            external_code_select
);

    // ****************************************
    // Edge detection and decode
    // ****************************************
    logic        ale_q;
    logic        wr_q;
    logic        pmode_q;
    logic        byte_armed;
    logic [5:0]  page;
    logic [1:0]  lock_bits;
    logic [1:0]  committed_bits;
    logic [15:0] wr_low_cnt;
    logic        lock_done;
    logic        ea_latched;
    opa_mode_e   mode;
    logic [7:0]  next_version;
    logic [7:0]  next_sfr;

    opa_mem_if mem_bus ();

    opa_otp_array u_array (
        .ref_clk (ref_clk),
        .mem     (mem_bus)
    );

    wire ale_rise = address_latch_strobe && !ale_q;
    wire ale_fall = !address_latch_strobe && ale_q;
    wire wr_fall  = !program_write_strobe_n && wr_q;

    // Version bytes in maker, type, stepping order; unmapped reads give zero.
    function automatic logic [7:0] version_of(input logic [7:0] a);
        case (a)
            `OPA_VER_ADDR0: version_of = `OPA_VER_MAKER;
            `OPA_VER_ADDR1: version_of = `OPA_VER_TYPE;
            `OPA_VER_ADDR2: version_of = VER_STEP;
            default:        version_of = 8'h00;
        endcase
    endfunction : version_of

    // Strobe and mode history, one register stage per pin.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ale_q   <= 1'b0;
            wr_q    <= 1'b1;
            pmode_q <= 1'b0;
        end else begin
            ale_q   <= address_latch_strobe;
            wr_q    <= program_write_strobe_n;
            pmode_q <= program_write_strobe_mode_active;
        end
    end

    // ****************************************
    // Access mode state
    // ****************************************
    // Byte mode needs a latch strobe rise under 1,1; any other select
    // disarms it, so a return from another mode needs a fresh strobe.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_armed <= 1'b0;
        end else if (!program_write_strobe_mode_active) begin
            byte_armed <= 1'b0;
        end else if (ale_rise && access_mode_select == `OPA_SEL_BYTE) begin
            byte_armed <= 1'b1;
        end else if (access_mode_select != `OPA_SEL_BYTE) begin
            byte_armed <= 1'b0;
        end
    end

    // Current mode; version and lock modes follow the select lines directly.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= OPA_MODE_IDLE;
        end else if (!program_write_strobe_mode_active) begin
            mode <= OPA_MODE_IDLE;
        end else begin
            case (access_mode_select)
                `OPA_SEL_BYTE:    mode <= byte_armed ? OPA_MODE_BYTE : OPA_MODE_IDLE;
                `OPA_SEL_LOCK:    mode <= OPA_MODE_LOCK;
                `OPA_SEL_VERSION: mode <= OPA_MODE_VERSION;
                default:          mode <= OPA_MODE_IDLE;
            endcase
        end
    end

    // Page register; it holds across any number of accesses.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            page <= 6'h00;
        end else if (ale_fall) begin
            page <= address_port[5:0];
        end
    end

    // ****************************************
    // OTP byte program and read
    // ****************************************
    // The write is taken at the strobe fall, when data is already stable.
    // Programming is refused once a non-zero level has been committed.
    assign mem_bus.addr  = {page, address_port};
    assign mem_bus.wdata = data_port_in;
    assign mem_bus.we    = wr_fall && mode == OPA_MODE_BYTE
                           && committed_bits == `OPA_LOCK_RESET;

    // ****************************************
    // Lock bits
    // ****************************************
    // Count the write strobe low time; a short pulse programs nothing.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_low_cnt <= 16'h0000;
        end else if (program_write_strobe_n || mode != OPA_MODE_LOCK) begin
            wr_low_cnt <= 16'h0000;
        end else if (!lock_done) begin
            wr_low_cnt <= wr_low_cnt + 16'h0001;
        end
    end

    // One programming event per pulse, after the full low time.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_done <= 1'b0;
        end else if (program_write_strobe_n) begin
            lock_done <= 1'b0;
        end else if (wr_low_cnt == 16'(LOCK_PULSE_CYC - 1)) begin
            lock_done <= 1'b1;
        end
    end

    // Fuse-like lock bits: a zero in the data programs that bit until sys_rst.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_bits <= `OPA_LOCK_RESET;
        end else if (mode == OPA_MODE_LOCK && !lock_done
                     && wr_low_cnt == 16'(LOCK_PULSE_CYC - 1)) begin
            lock_bits <= lock_bits & data_port_in[1:0];
        end
    end

    // Protection takes hold only when programming mode is left.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            committed_bits <= `OPA_LOCK_RESET;
        end else if (pmode_q && !program_write_strobe_mode_active) begin
            committed_bits <= lock_bits;
        end
    end

    // ****************************************
    // Read data path
    // ****************************************
    // Byte data arrives from the array one cycle after the address,
    // so the data register always reloads while the strobe is low.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_port_out <= 8'h00;
        end else if (!program_read_strobe_n) begin
            case (mode)
                OPA_MODE_BYTE:    data_port_out <= mem_bus.rdata;
                OPA_MODE_LOCK:    data_port_out <= {6'h00, lock_bits};
                OPA_MODE_VERSION: data_port_out <= version_of(version_address_port);
                default:          data_port_out <= 8'h00;
            endcase
        end
    end

    // Drive the port only during a read; writes in version mode do nothing.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_port_oe <= 1'b0;
        end else begin
            data_port_oe <= !program_read_strobe_n && program_write_strobe_mode_active;
        end
    end

    // ****************************************
    // Normal-mode register view
    // ****************************************
    always_comb begin
        next_version = version_of(sfr_address);
        next_sfr     = sfr_map_select ? next_version : 8'h00;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_read_data <= 8'h00;
        end else if (sfr_read) begin
            sfr_read_data <= next_sfr;
        end
    end

    // ****************************************
    // Protection outputs
    // ****************************************
    // The access pin is caught while the core sits in reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ea_latched <= 1'b0;
        end else if (device_in_reset) begin
            ea_latched <= external_access_pin;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            protection_level     <= 2'h0;
            program_write_strobe_entry_refused   <= 1'b0;
            table_read_blocked   <= 1'b0;
            verify_mode2_blocked <= 1'b0;
            programming_blocked  <= 1'b0;
            external_code_select <= 1'b0;
        end else begin
            protection_level     <= opa_level_of(committed_bits);
            program_write_strobe_entry_refused   <= opa_level_of(committed_bits) != 2'h0;
            table_read_blocked   <= opa_level_of(committed_bits) != 2'h0;
            verify_mode2_blocked <= opa_level_of(committed_bits) >= 2'h2;
            programming_blocked  <= opa_level_of(committed_bits) != 2'h0;
            case (opa_level_of(committed_bits))
                2'h0:    external_code_select <= external_access_pin;
                2'h3:    external_code_select <= 1'b0;
                default: external_code_select <= ea_latched;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_page_capture: assert property (ale_fall |=> page == $past(address_port[5:0]))
        else $error("page not captured at latch strobe fall");
    a_page_hold: assert property (!ale_fall |=> $stable(page))
        else $error("page changed without latch strobe");
    a_byte_arm: assert property (program_write_strobe_mode_active && ale_rise
        && access_mode_select == `OPA_SEL_BYTE |=> byte_armed)
        else $error("byte mode not armed");
    a_mode_disarm: assert property (access_mode_select != `OPA_SEL_BYTE |=> !byte_armed)
        else $error("byte mode stayed armed");
    a_lock_read: assert property (!program_read_strobe_n && mode == OPA_MODE_LOCK
        |=> data_port_out == {6'h00, $past(lock_bits)})
        else $error("lock bits not returned");
    a_port_release: assert property (program_read_strobe_n |=> !data_port_oe)
        else $error("data port driven without read strobe");
    a_version_ro: assert property (mode == OPA_MODE_VERSION |-> !mem_bus.we)
        else $error("write in version mode");
    a_commit_exit: assert property (committed_bits != $past(committed_bits)
        |-> $past(pmode_q) && !$past(program_write_strobe_mode_active))
        else $error("protection committed inside programming mode");
    a_program_write_strobe_refuse: assert property (committed_bits != `OPA_LOCK_RESET |-> !mem_bus.we)
        else $error("byte programmed while protected");
    a_entry_refused: assert property (committed_bits != `OPA_LOCK_RESET
        |=> program_write_strobe_entry_refused && table_read_blocked)
        else $error("protection outputs not raised");
    a_lock_pulse: assert property (lock_bits != $past(lock_bits)
        |-> $past(wr_low_cnt) == 16'(LOCK_PULSE_CYC - 1))
        else $error("lock bits changed on a short pulse");
    a_sfr_map: assert property (sfr_read && sfr_map_select && sfr_address == `OPA_VER_ADDR0
        |=> sfr_read_data == `OPA_VER_MAKER)
        else $error("mapped version register wrong");

    c_byte_write: cover property (mem_bus.we);
    c_lock_program_write_strobe: cover property (mode == OPA_MODE_LOCK && lock_done);
    c_version_read: cover property (mode == OPA_MODE_VERSION && data_port_oe);

endmodule : opa_program_write_strobe_access
`default_nettype wire

// file: design/opa_defines.svh
// Purpose: Constants for the OTP programming access block.
// Assumes: Included by bare name from design files.
// Notes:   Offsets, codes, sizes, reset values and timing only.
`ifndef OPA_DEFINES_SVH
`define OPA_DEFINES_SVH

// ****************************************
// Access mode select codes
// ****************************************
`define OPA_SEL_BYTE     2'h3
`define OPA_SEL_LOCK     2'h2
`define OPA_SEL_VERSION  2'h1

// ****************************************
// Version byte addresses and contents
// ****************************************
`define OPA_VER_ADDR0    8'hfc
`define OPA_VER_ADDR1    8'hfd
`define OPA_VER_ADDR2    8'hfe
// Arbitrary identity values, not any real part.
`define OPA_VER_MAKER    8'h5a
`define OPA_VER_TYPE     8'h3c
`define OPA_VER_STEP     8'h07

// ****************************************
// Address layout and reset values
// ****************************************
`define OPA_ADDR_W       14
`define OPA_PAGE_W       6
`define OPA_MEM_DEPTH    16384
`define OPA_LOCK_RESET   2'h3
`define OPA_ERASED_BYTE  8'hff

// ****************************************
// Timing
// ****************************************
`define OPA_LOCK_PULSE_US 100
`define OPA_CLK_MHZ       50

`endif

// file: design/opa_pkg.sv
// Purpose: Types shared by the OTP programming access block.
// Assumes: Compiled before all other design files.
// Notes:   Constants live in opa_defines.svh.
package opa_pkg;

    // Access mode decoded from the select lines.
    typedef enum logic [1:0] {
        OPA_MODE_IDLE    = 2'b00,
        OPA_MODE_VERSION = 2'b01,
        OPA_MODE_LOCK    = 2'b10,
        OPA_MODE_BYTE    = 2'b11
    } opa_mode_e;

    typedef logic [1:0] opa_level_t;

    // Lock bit pair to protection level; a cleared bit is programmed.
    function automatic opa_level_t opa_level_of(input logic [1:0] bits);
        opa_level_of = ~bits;
    endfunction : opa_level_of

endpackage : opa_pkg

// file: design/opa_mem_if.sv
// Purpose: Carrier between the access logic and the OTP array.
// Assumes: One clock; read data follows the address by one cycle.
// Notes:   We is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface opa_mem_if;
    logic [13:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;

    modport ctrl  (output addr, output wdata, output we, input rdata);
    modport store (input addr, input wdata, input we, output rdata);
endinterface : opa_mem_if
`default_nettype wire

// file: design/opa_otp_array.sv
// Purpose: Byte array standing in for the one-time-programmable store.
// Assumes: Writes only clear bits, as a fuse array would.
// Notes:   Read data is registered, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "opa_defines.svh"
module opa_otp_array
    import opa_pkg::*;
(
    input  wire logic  ref_clk,
    opa_mem_if.store   mem
);

    logic [7:0] cells [0:`OPA_MEM_DEPTH-1];

    // Start erased so an unwritten byte reads as all ones.
    initial begin
        for (int i = 0; i < `OPA_MEM_DEPTH; i++) begin
            cells[i] = `OPA_ERASED_BYTE;
        end
    end

    // Programming can only move bits from one to zero.
    always_ff @(posedge ref_clk) begin
        if (mem.we) begin
            cells[mem.addr] <= cells[mem.addr] & mem.wdata;
        end
    end

    // Registered read port.
    always_ff @(posedge ref_clk) begin
        mem.rdata <= cells[mem.addr];
    end

endmodule : opa_otp_array
`default_nettype wire

// file: bench/opa_programmer.sv
// Purpose: Model of the external programmer that drives the programming pins.
// Assumes: Every pin change lands on a falling edge of ref_clk.
// Notes:   Port 0 shows an inverted pattern whenever nobody drives it.
`timescale 1ns/1ps
`default_nettype none
`include "opa_defines.svh"
module opa_programmer
    import opa_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_port_out,
    input  wire logic       data_port_oe,
    output logic            program_write_strobe_mode_active,
    output logic      [1:0] access_mode_select,
    output logic            address_latch_strobe,
    output logic            program_write_strobe_n,
    output logic            program_read_strobe_n,
    output logic      [7:0] address_port,
    output logic      [7:0] version_address_port,
    output logic      [7:0] data_port_in
);
    logic       drv_en;
    logic [7:0] drv_data;

    // Wire level of port 0; a released line never keeps its last value.
    assign data_port_in = data_port_oe ? data_port_out : (drv_en ? drv_data : ~data_port_out);

    // Idle pins: strobes high, latch low, programming select released.
    initial begin
        program_write_strobe_mode_active       = 1'b0;
        access_mode_select     = 2'h0;
        address_latch_strobe   = 1'b0;
        program_write_strobe_n = 1'b1;
        program_read_strobe_n  = 1'b1;
        address_port           = 8'h00;
        version_address_port   = 8'h00;
        drv_en                 = 1'b0;
        drv_data               = 8'h00;
    end

    // Programming select is held for the whole run of accesses.
    task automatic set_program_write_strobe(input logic on);
        @(negedge ref_clk);
        program_write_strobe_mode_active = on;
    endtask : set_program_write_strobe

    // Selects a mode; a latch pulse follows except for version reads.
    task automatic enter(input logic [1:0] sel, input logic [5:0] page);
        @(negedge ref_clk);
        access_mode_select = sel;
        address_port       = {2'h0, page};
        if (sel != `OPA_SEL_VERSION) begin
            @(negedge ref_clk);
            address_latch_strobe = 1'b1;
            @(negedge ref_clk);
            address_latch_strobe = 1'b0;
        end
        @(negedge ref_clk);
    endtask : enter

    // One strobed access; lines change only while both strobes are high.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input int hold, output logic [7:0] rdata, output logic oe_seen);
        @(negedge ref_clk);
        address_port         = addr;
        version_address_port = addr;
        drv_en               = wr;
        drv_data             = wdata;
        @(negedge ref_clk);
        if (wr) begin
            program_write_strobe_n = 1'b0;
        end else begin
            program_read_strobe_n = 1'b0;
        end
        repeat (hold) @(negedge ref_clk);
        rdata                  = data_port_out;
        oe_seen                = data_port_oe;
        program_write_strobe_n = 1'b1;
        program_read_strobe_n  = 1'b1;
        @(negedge ref_clk);
        drv_en = 1'b0;
    endtask : access
endmodule : opa_programmer
`default_nettype wire

// file: bench/otp_program_interface_access_bench.sv
// Purpose: Self-checking bench for the OTP programming access block.
// Assumes: Short lock pulse parameter; array starts erased.
// Notes:   Table rows cover byte and version accesses; lock levels follow.
`timescale 1ns/1ps
`default_nettype none
`include "opa_defines.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module otp_program_interface_access_bench
    import opa_pkg::*;
;
    typedef struct {logic ver; logic [13:0] addr; logic [7:0] wdata; logic [7:0] exp;} opa_row_s;
    localparam int         LOCK_CYC = 8;
    localparam logic [7:0] STEP     = 8'h08; // Arbitrary later stepping value.
    logic       ref_clk, sys_rst, pm, ale, wr_n, rd_n, oe, dev_rst, ea, map_sel, sfr_rd;
    logic       ecs, refused, tbl_blk, vm2_blk, prg_blk, last_ver, seen;
    logic [1:0] sel, level;
    logic [5:0] page;
    logic [7:0] addr, vaddr, din, dout, sfr_addr, sfr_data, rd;
    int         failures, checked;
    opa_row_s   rows [10];

    // ****************************************
    // Clock, partner and design
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    opa_programmer program_write_strobe_u (.ref_clk(ref_clk), .data_port_out(dout), .data_port_oe(oe),
        .program_write_strobe_mode_active(pm), .access_mode_select(sel), .address_latch_strobe(ale),
        .program_write_strobe_n(wr_n), .program_read_strobe_n(rd_n), .address_port(addr),
        .version_address_port(vaddr), .data_port_in(din));
    opa_program_write_strobe_access #(.LOCK_PULSE_CYC(LOCK_CYC), .VER_STEP(STEP)) dut_u (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .program_write_strobe_mode_active(pm), .access_mode_select(sel),
        .address_latch_strobe(ale), .program_write_strobe_n(wr_n), .program_read_strobe_n(rd_n),
        .address_port(addr), .version_address_port(vaddr), .data_port_in(din),
        .data_port_out(dout), .data_port_oe(oe), .device_in_reset(dev_rst),
        .external_access_pin(ea), .sfr_map_select(map_sel), .sfr_read(sfr_rd),
        .sfr_address(sfr_addr), .sfr_read_data(sfr_data), .protection_level(level),
        .program_write_strobe_entry_refused(refused), .table_read_blocked(tbl_blk),
        .verify_mode2_blocked(vm2_blk), .programming_blocked(prg_blk),
        .external_code_select(ecs));

    // ****************************************
    // Tasks
    // ****************************************
    // Prints the counts and the verdict, then stops the run.
    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Holds reset for 20 cycles; lock bits return to the erased pair.
    task automatic do_reset();
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(level, 2'h0)
        `CHK(oe, 1'b0)
    endtask : do_reset

    // A hang never passes: the watchdog counts it and closes the run.
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        summarize();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_rst  = 1'b1;
        dev_rst  = 1'b0;
        ea       = 1'b0;
        map_sel  = 1'b1;
        sfr_rd   = 1'b0;
        sfr_addr = 8'h00;
        failures = 0;
        checked  = 0;
        last_ver = 1'b1;
        page     = 6'h00;
        rows[0] = '{1'b0, 14'h03fd, 8'ha5, 8'ha5};
        rows[1] = '{1'b0, 14'h03fe, 8'h3c, 8'h3c};
        rows[2] = '{1'b0, 14'h03ff, 8'h00, 8'h00};
        rows[3] = '{1'b0, 14'h0400, 8'hf0, 8'hf0};
        rows[4] = '{1'b0, 14'h0400, 8'h3c, 8'h30};
        rows[5] = '{1'b0, 14'h03fd, 8'h0f, 8'h05};
        rows[6] = '{1'b1, 14'h00fc, 8'h00, `OPA_VER_MAKER};
        rows[7] = '{1'b1, 14'h00fd, 8'h00, `OPA_VER_TYPE};
        rows[8] = '{1'b1, 14'h00fe, 8'h00, STEP};
        rows[9] = '{1'b1, 14'h00fb, 8'h00, 8'h00};
        do_reset();
        program_write_strobe_u.set_program_write_strobe(1'b1);
        // Rows: byte pages with fuse AND, then version bytes with a write attempt.
        for (int i = 0; i < 10; i++) begin
            if (rows[i].ver) begin
                if (!last_ver) program_write_strobe_u.enter(`OPA_SEL_VERSION, 6'h00);
                program_write_strobe_u.access(1'b1, rows[i].addr[7:0], ~rows[i].exp, 2, rd, seen);
                program_write_strobe_u.access(1'b0, rows[i].addr[7:0], 8'h00, 3, rd, seen);
                `CHK(rd, rows[i].exp)
                if (rows[i].exp !== 8'h00) begin
                    @(negedge ref_clk);
                    sfr_addr = rows[i].addr[7:0];
                    sfr_rd   = 1'b1;
                    @(negedge ref_clk);
                    sfr_rd = 1'b0;
                    `CHK(sfr_data, rows[i].exp)
                end
            end else begin
                if (last_ver || rows[i].addr[13:8] != page) program_write_strobe_u.enter(`OPA_SEL_BYTE, rows[i].addr[13:8]);
                page = rows[i].addr[13:8];
                program_write_strobe_u.access(1'b1, rows[i].addr[7:0], rows[i].wdata, 2, rd, seen);
                program_write_strobe_u.access(1'b0, rows[i].addr[7:0], 8'h00, 3, rd, seen);
                `CHK(rd, rows[i].exp)
            end
            `CHK(seen, 1'b1)
            @(negedge ref_clk);
            `CHK(oe, 1'b0)
            last_ver = rows[i].ver;
            $display("row %0d done", i);
        end
        // Lock pairs 11, 10, 01, 00 in turn, each from a fresh reset.
        for (int k = 0; k < 4; k++) begin
            do_reset();
            program_write_strobe_u.set_program_write_strobe(1'b1);
            program_write_strobe_u.enter(`OPA_SEL_LOCK, 6'h00);
            if (k == 0) begin
                program_write_strobe_u.access(1'b1, 8'h00, 8'h00, LOCK_CYC - 2, rd, seen);
                program_write_strobe_u.access(1'b0, 8'h00, 8'h00, 3, rd, seen);
                `CHK(rd[1:0], 2'h3)
            end
            program_write_strobe_u.access(1'b1, 8'h00, {6'h00, 2'(3 - k)}, LOCK_CYC + 2, rd, seen);
            program_write_strobe_u.access(1'b0, 8'h00, 8'h00, 3, rd, seen);
            `CHK(rd[1:0], 2'(3 - k))
            `CHK(level, 2'h0)
            program_write_strobe_u.enter(`OPA_SEL_BYTE, 6'h04);
            program_write_strobe_u.access(1'b0, 8'h00, 8'h00, 3, rd, seen);
            `CHK(rd, 8'h30)
            program_write_strobe_u.set_program_write_strobe(1'b0);
            repeat (3) @(negedge ref_clk);
            dev_rst = 1'b1;
            ea      = 1'b1;
            repeat (2) @(negedge ref_clk);
            dev_rst = 1'b0;
            ea      = 1'b0;
            repeat (2) @(negedge ref_clk);
            `CHK(level, 2'(k))
            `CHK(refused, (k != 0))
            `CHK(tbl_blk, (k >= 1))
            `CHK(prg_blk, (k >= 1))
            `CHK(vm2_blk, (k >= 2))
            `CHK(ecs, (k == 1 || k == 2))
            // With level 1 committed, a byte write must leave the array alone.
            if (k == 1) begin
                program_write_strobe_u.set_program_write_strobe(1'b1);
                program_write_strobe_u.enter(`OPA_SEL_BYTE, 6'h04);
                program_write_strobe_u.access(1'b1, 8'h00, 8'h00, 2, rd, seen);
                program_write_strobe_u.access(1'b0, 8'h00, 8'h00, 3, rd, seen);
                `CHK(rd, 8'h30)
            end
            $display("lock case %0d done", k);
        end
        summarize();
    end
endmodule : otp_program_interface_access_bench
`undef CHK
`default_nettype wire
